// File: verilog/ecl_loader.v
// EEPROM configuration loader with APB control and status
//
// Overview of operation
// - Word 00h must match the signature before any other word is used.
// - Word 06h bit 0 goes to 144h bit 0 on all ports.
// - Word 06h bits 3:1 go to CCh bits 14:12 on all ports.
// - Word 06h bits 6:4 go to CCh bits 17:15 on all ports.
// - Word 06h bit 7 goes to CCh bit 18 on all ports.
// - Word 06h bit 8 goes to 74h bit 5 of port 0.
// - Word 06h bit 9 goes to 74h bit 6 of port 0.
// - Word 06h bit 10 goes to 74h bit 0 of port 0.
// - Word 06h bits 12:11 go to 74h bits 2:1 of port 0.
// - Word 06h bit 13 goes to 74h bit 3 of port 0.
// - Word 06h bit 14 goes to 74h bit 4 of port 0.
// - Word 06h bit 15 goes to 74h bit 7 of port 0.
// - Word 0Ch bits 1:0 go to C4h bits 1:0 on all ports.
// - Word 0Ch bits 3:2 go to CCh bits 11:10 on all ports.
// - Word 0Ch bit 4 goes to C4h bit 15 on all ports.
// - Word 0Ch bit 5 goes to 70h bit 14 on all ports.
// - Word 0Ch bit 6 goes to 74h bit 15 on all ports.
// - Word 0Ch bit 7 goes to 70h bit 13 on all ports.
// - Word 0Ch bit 8 goes to 8Ch bit 5 on all ports.
`timescale 1ns/100ps
`include "ecl_defines.vh"
module ecl_loader (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    // EEPROM word stream from the serial reader
    input wire ee_word_valid,
    input wire [7:0] ee_word_addr,
    input wire [15:0] ee_word_data,
    input wire ee_word_last,
    output reg ee_word_ready_q,
    // Identifier registers
    output reg [15:0] vendor_id_q,
    output reg [15:0] device_id_q,
    output reg [15:0] subsys_vendor_id_q,
    output reg [15:0] subsys_id_q,
    // Port 0 switch mode fields
    output reg sw_no_order_egress_q,
    output reg sw_no_order_tag_q,
    output reg sw_store_fwd_q,
    output reg [1:0] sw_cut_thresh_q,
    output reg sw_arb_mode_q,
    output reg sw_credit_mode_q,
    output reg sw_np_store_fwd_q,
    // Per-port fields, port n in slice n
    output wire [5:0] vc_ext,
    output wire [17:0] l0s_lat,
    output wire [17:0] l1_lat,
    output wire [5:0] clk_pm,
    output wire [11:0] mps,
    output wire [11:0] aspm,
    output wire [5:0] rber,
    output wire [5:0] msi_dis,
    output wire [5:0] cpp_dis,
    output wire [5:0] pm_dis,
    output wire [5:0] posted_pass_nonposted_enable,
    // Load status
    output reg load_done_q,
    output reg sig_err_q
);

localparam ST_IDLE = 2'h0;
localparam ST_SIG = 2'h1;
localparam ST_LOAD = 2'h2;

reg [1:0] state_q;
reg [1:0] state_d;
reg [15:0] sig_exp_q;
reg [15:0] sig_seen_q;
reg [15:0] w06_q;
reg [15:0] w0c_q;
reg sig_ok_q;
reg start_q;

wire apb_setup;
wire apb_wr;
wire word_take;
wire sig_match;
wire ld_w06;
wire ld_w0c;
reg [31:0] rd_d;
reg map_d;

assign apb_setup = psel & penable & ~pready_q;
assign apb_wr = apb_setup & pwrite;
// Words are only consumed while the loader is ready for them
assign word_take = ee_word_valid & ee_word_ready_q;
assign sig_match = (ee_word_data == sig_exp_q);
assign ld_w06 = word_take & (state_q == ST_LOAD) & (ee_word_addr == `ECL_EE_W06);
assign ld_w0c = word_take & (state_q == ST_LOAD) & (ee_word_addr == `ECL_EE_W0C);

// Start request from software, restarts a load from the signature
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        start_q <= 1'b0;
    end else begin
        start_q <= apb_wr & (paddr == `ECL_REG_CTRL) & pwdata[`ECL_CTRL_START];
    end
end

always @* begin
    state_d = state_q;
    case (state_q)
        ST_IDLE: begin
            if (start_q) begin
                state_d = ST_SIG;
            end
        end
        ST_SIG: begin
            // Anything before the signature word is skipped
            if (word_take && ee_word_addr == `ECL_EE_SIG) begin
                state_d = sig_match ? ST_LOAD : ST_IDLE;
            end
        end
        ST_LOAD: begin
            if (word_take && ee_word_last) begin
                state_d = ST_IDLE;
            end
        end
        default: begin
            state_d = ST_IDLE;
        end
    endcase
end

// Loading starts by itself after reset
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_q <= ST_SIG;
        ee_word_ready_q <= 1'b0;
    end else begin
        state_q <= state_d;
        ee_word_ready_q <= (state_d != ST_IDLE);
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        load_done_q <= 1'b0;
        sig_err_q <= 1'b0;
        sig_ok_q <= 1'b0;
        sig_seen_q <= `ECL_ZERO16;
    end else if (state_q == ST_SIG && word_take && ee_word_addr == `ECL_EE_SIG) begin
        sig_seen_q <= ee_word_data;
        sig_ok_q <= sig_match;
        sig_err_q <= ~sig_match;
        load_done_q <= 1'b0;
    end else if (state_q == ST_LOAD && word_take && ee_word_last) begin
        load_done_q <= 1'b1;
    end else if (start_q && state_q == ST_IDLE) begin
        // A start during a load is ignored, so its status must stand
        load_done_q <= 1'b0;
        sig_err_q <= 1'b0;
        sig_ok_q <= 1'b0;
    end
end

// Identifier words; a bad signature leaves the previous values in place
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        vendor_id_q <= `ECL_ZERO16;
        device_id_q <= `ECL_ZERO16;
        subsys_vendor_id_q <= `ECL_ZERO16;
        subsys_id_q <= `ECL_ZERO16;
    end else if (word_take && state_q == ST_LOAD) begin
        case (ee_word_addr)
            `ECL_EE_VID: vendor_id_q <= ee_word_data;
            `ECL_EE_DID: device_id_q <= ee_word_data;
            `ECL_EE_SSVID: subsys_vendor_id_q <= ee_word_data;
            `ECL_EE_SSID: subsys_id_q <= ee_word_data;
            default: begin
            end
        endcase
    end
end

// Raw image copies kept for software readback
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        w06_q <= `ECL_ZERO16;
        w0c_q <= `ECL_ZERO16;
    end else begin
        if (ld_w06) begin
            w06_q <= ee_word_data;
        end
        if (ld_w0c) begin
            w0c_q <= ee_word_data;
        end
    end
end

// Switch mode fields exist on port 0 only
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sw_no_order_egress_q <= 1'b0;
        sw_no_order_tag_q <= 1'b0;
        sw_store_fwd_q <= 1'b0;
        sw_cut_thresh_q <= 2'h0;
        sw_arb_mode_q <= 1'b0;
        sw_credit_mode_q <= 1'b0;
        sw_np_store_fwd_q <= 1'b0;
    end else if (ld_w06) begin
        sw_no_order_egress_q <= ee_word_data[`ECL_W06_NOEG];
        sw_no_order_tag_q <= ee_word_data[`ECL_W06_NOTAG];
        sw_store_fwd_q <= ee_word_data[`ECL_W06_SF];
        sw_cut_thresh_q <= ee_word_data[`ECL_W06_CT];
        sw_arb_mode_q <= ee_word_data[`ECL_W06_ARB];
        sw_credit_mode_q <= ee_word_data[`ECL_W06_CRED];
        sw_np_store_fwd_q <= ee_word_data[`ECL_W06_NPSF];
    end
end

// Broadcast fields, one copy per port
genvar gi;
generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_port
        ecl_port_cfg u_port (
            .pclk(pclk),
            .presetn(presetn),
            .ld_w06(ld_w06),
            .ld_w0c(ld_w0c),
            .word(ee_word_data),
            .vc_ext_q(vc_ext[gi]),
            .l0s_lat_q(l0s_lat[gi*3 +: 3]),
            .l1_lat_q(l1_lat[gi*3 +: 3]),
            .clk_pm_q(clk_pm[gi]),
            .mps_q(mps[gi*2 +: 2]),
            .aspm_q(aspm[gi*2 +: 2]),
            .rber_q(rber[gi]),
            .msi_dis_q(msi_dis[gi]),
            .cpp_dis_q(cpp_dis[gi]),
            .pm_dis_q(pm_dis[gi]),
            .posted_pass_nonposted_enable_q(posted_pass_nonposted_enable[gi])
        );
    end
endgenerate

// Expected signature; a write takes effect for the next signature check
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sig_exp_q <= `ECL_SIG_RST;
    end else if (apb_wr && paddr == `ECL_REG_SIGEXP) begin
        sig_exp_q <= pwdata[15:0];
    end
end

// Read mux
always @* begin
    rd_d = `ECL_ZERO32;
    map_d = 1'b1;
    case (paddr)
        `ECL_REG_CTRL: rd_d = `ECL_ZERO32;
        `ECL_REG_STAT: begin
            rd_d[`ECL_STAT_BUSY] = (state_q != ST_IDLE);
            rd_d[`ECL_STAT_DONE] = load_done_q;
            rd_d[`ECL_STAT_SIGERR] = sig_err_q;
            rd_d[`ECL_STAT_SIGOK] = sig_ok_q;
        end
        `ECL_REG_SIGSEEN: rd_d = {16'h0000, sig_seen_q};
        `ECL_REG_ID: rd_d = {device_id_q, vendor_id_q};
        `ECL_REG_SSID: rd_d = {subsys_id_q, subsys_vendor_id_q};
        `ECL_REG_W06: rd_d = {16'h0000, w06_q};
        `ECL_REG_W0C: rd_d = {16'h0000, w0c_q};
        `ECL_REG_SIGEXP: rd_d = {16'h0000, sig_exp_q};
        default: map_d = 1'b0;
    endcase
end

// One wait state: pready rises in the second access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
        prdata_q <= `ECL_ZERO32;
    end else begin
        pready_q <= apb_setup;
        pslverr_q <= apb_setup & ~map_d;
        if (apb_setup && !pwrite) begin
            prdata_q <= rd_d;
        end else begin
            prdata_q <= `ECL_ZERO32;
        end
    end
end

endmodule

// File: verilog/ecl_defines.vh
// Constants for the EEPROM configuration loader
`ifndef ECL_DEFINES_VH
`define ECL_DEFINES_VH
// Image word byte addresses
`define ECL_EE_SIG 8'h00
`define ECL_EE_VID 8'h02
`define ECL_EE_DID 8'h04
`define ECL_EE_W06 8'h06
`define ECL_EE_SSVID 8'h08
`define ECL_EE_SSID 8'h0A
`define ECL_EE_W0C 8'h0C
// Expected signature reset value, arbitrary
`define ECL_SIG_RST 16'hA55A
// APB register byte offsets
`define ECL_REG_CTRL 8'h00
`define ECL_REG_STAT 8'h04
`define ECL_REG_SIGSEEN 8'h08
`define ECL_REG_ID 8'h0C
`define ECL_REG_SSID 8'h10
`define ECL_REG_W06 8'h14
`define ECL_REG_W0C 8'h18
`define ECL_REG_SIGEXP 8'h1C
// Control and status bits
`define ECL_CTRL_START 0
`define ECL_STAT_BUSY 0
`define ECL_STAT_DONE 1
`define ECL_STAT_SIGERR 2
`define ECL_STAT_SIGOK 3
// Word 06h source fields
`define ECL_W06_VC 0
`define ECL_W06_L0S 3:1
`define ECL_W06_L1 6:4
`define ECL_W06_CPM 7
`define ECL_W06_NOEG 8
`define ECL_W06_NOTAG 9
`define ECL_W06_SF 10
`define ECL_W06_CT 12:11
`define ECL_W06_ARB 13
`define ECL_W06_CRED 14
`define ECL_W06_NPSF 15
// Word 0Ch source fields
`define ECL_W0C_MPS 1:0
`define ECL_W0C_ASPM 3:2
`define ECL_W0C_RBER 4
`define ECL_W0C_MSID 5
`define ECL_W0C_CPPD 6
`define ECL_W0C_PMD 7
`define ECL_W0C_PPNP 8
// Reset values
`define ECL_ZERO16 16'h0000
`define ECL_ZERO32 32'h00000000
`endif

// File: verilog/ecl_port_cfg.v
// Per-port configuration fields loaded from the EEPROM image
`timescale 1ns/100ps
`include "ecl_defines.vh"
module ecl_port_cfg (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Load strobes and word
    input wire ld_w06,
    input wire ld_w0c,
    input wire [15:0] word,
    // Fields
    output reg vc_ext_q,
    output reg [2:0] l0s_lat_q,
    output reg [2:0] l1_lat_q,
    output reg clk_pm_q,
    output reg [1:0] mps_q,
    output reg [1:0] aspm_q,
    output reg rber_q,
    output reg msi_dis_q,
    output reg cpp_dis_q,
    output reg pm_dis_q,
    output reg posted_pass_nonposted_enable_q
);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        vc_ext_q <= 1'b0;
        l0s_lat_q <= 3'h0;
        l1_lat_q <= 3'h0;
        clk_pm_q <= 1'b0;
    end else if (ld_w06) begin
        vc_ext_q <= word[`ECL_W06_VC];
        l0s_lat_q <= word[`ECL_W06_L0S];
        l1_lat_q <= word[`ECL_W06_L1];
        clk_pm_q <= word[`ECL_W06_CPM];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mps_q <= 2'h0;
        aspm_q <= 2'h0;
        rber_q <= 1'b0;
        msi_dis_q <= 1'b0;
        cpp_dis_q <= 1'b0;
        pm_dis_q <= 1'b0;
        posted_pass_nonposted_enable_q <= 1'b0;
    end else if (ld_w0c) begin
        mps_q <= word[`ECL_W0C_MPS];
        aspm_q <= word[`ECL_W0C_ASPM];
        rber_q <= word[`ECL_W0C_RBER];
        msi_dis_q <= word[`ECL_W0C_MSID];
        cpp_dis_q <= word[`ECL_W0C_CPPD];
        pm_dis_q <= word[`ECL_W0C_PMD];
        posted_pass_nonposted_enable_q <= word[`ECL_W0C_PPNP];
    end
end

endmodule

// File: verification/ecl_loader_sva.sv
// Assertions on the EEPROM configuration loader ports
`timescale 1ns/100ps
module ecl_loader_sva (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Word stream
    input wire ee_word_valid,
    input wire ee_word_ready_q,
    input wire [7:0] ee_word_addr,
    input wire [15:0] ee_word_data,
    // Fields
    input wire [15:0] vendor_id_q,
    input wire [5:0] vc_ext,
    input wire [17:0] l0s_lat,
    input wire [5:0] clk_pm,
    input wire sw_store_fwd_q,
    input wire [11:0] mps,
    input wire [5:0] posted_pass_nonposted_enable,
    input wire sig_err_q
);
    // Words count only after a good signature in this load
    reg got_q;
    reg [15:0] dat_q;
    wire acc = ee_word_valid && ee_word_ready_q;
    wire ok = acc && got_q && !sig_err_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_q <= 1'b0;
            dat_q <= 16'h0000;
        end else begin
            dat_q <= ee_word_data;
            got_q <= ee_word_ready_q && (got_q || (acc && ee_word_addr == 8'h00));
        end
    end
    vc_copy_a: assert property (ok && ee_word_addr == 8'h06 |=> vc_ext == {6{dat_q[0]}})
        else $error("vc count copy");
    l0s_copy_a: assert property (ok && ee_word_addr == 8'h06 |=> l0s_lat == {6{dat_q[3:1]}})
        else $error("l0s latency copy");
    clk_pm_a: assert property (ok && ee_word_addr == 8'h06 |=> clk_pm == {6{dat_q[7]}})
        else $error("clock pm copy");
    store_fwd_a: assert property (ok && ee_word_addr == 8'h06 |=> sw_store_fwd_q == dat_q[10])
        else $error("store forward copy");
    payload_copy_a: assert property (ok && ee_word_addr == 8'h0C |=> mps == {6{dat_q[1:0]}})
        else $error("payload size copy");
    pass_np_a: assert property (ok && ee_word_addr == 8'h0C |=> posted_pass_nonposted_enable == {6{dat_q[8]}})
        else $error("posted pass copy");
    vendor_copy_a: assert property (ok && ee_word_addr == 8'h02 |=> vendor_id_q == dat_q)
        else $error("vendor id copy");
    bad_sig_a: assert property (sig_err_q |-> $stable(vendor_id_q) && $stable(vc_ext) && $stable(mps))
        else $error("load after bad signature");
endmodule
bind ecl_loader ecl_loader_sva chk_u (.pclk, .presetn, .ee_word_valid, .ee_word_ready_q, .ee_word_addr,
    .ee_word_data, .vendor_id_q, .vc_ext, .l0s_lat, .clk_pm, .sw_store_fwd_q, .mps,
    .posted_pass_nonposted_enable, .sig_err_q);

// File: verification/ecl_ee_model.sv
// Behavioural EEPROM word reader feeding the loader
`timescale 1ns/100ps
module ecl_ee_model (
    // Clock and bench control
    input wire pclk,
    input wire run,
    input wire slow,
    // Image contents
    input wire [15:0] sig,
    input wire [15:0] w06,
    input wire [15:0] w0c,
    input wire [15:0] id,
    // Word stream
    input wire ready,
    output reg valid,
    output reg [7:0] addr,
    output reg [15:0] data,
    output reg last
);
    reg [2:0] idx_q;
    reg done_q;
    wire [111:0] img = {w0c, id ^ 16'hF0F0, id ^ 16'h0F0F, w06, ~id, id, sig};
    initial begin
        valid = 1'b0;
        addr = 8'h00;
        data = 16'h0000;
        last = 1'b0;
    end
    // Data toggles between offers so a stale capture cannot pass
    always @(posedge pclk) begin
        if (!run) begin
            idx_q <= 3'h0;
            done_q <= 1'b0;
            valid <= 1'b0;
            data <= ~data;
        end else if (valid && ready && (last || slow)) begin
            valid <= 1'b0;
            done_q <= last;
            data <= ~data;
        end else if (!done_q && (!valid || ready)) begin
            valid <= 1'b1;
            addr <= {4'h0, idx_q, 1'b0};
            data <= img[idx_q * 16 +: 16];
            last <= (idx_q == 3'h6);
            idx_q <= idx_q + 3'h1;
        end else if (!valid) begin
            data <= ~data;
        end
    end
endmodule

// File: verification/ecl_loader_tb.sv
// Self-checking bench for the EEPROM configuration loader
`timescale 1ns/100ps
`include "ecl_defines.vh"
module ecl_loader_tb;
    reg pclk, presetn, psel, penable, pwrite, run, slow, er_v;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd_v;
    reg [15:0] sig, w06, w0c, id;
    integer fails, cmp_count;
    wire pready_q, pslverr_q, ee_word_valid, ee_word_last, ee_word_ready_q, load_done_q, sig_err_q;
    wire sw_no_order_egress_q, sw_no_order_tag_q, sw_store_fwd_q, sw_arb_mode_q, sw_credit_mode_q, sw_np_store_fwd_q;
    wire [31:0] prdata_q;
    wire [7:0] ee_word_addr;
    wire [15:0] ee_word_data, vendor_id_q, device_id_q, subsys_vendor_id_q, subsys_id_q;
    wire [1:0] sw_cut_thresh_q;
    wire [5:0] vc_ext, clk_pm, rber, msi_dis, cpp_dis, pm_dis, posted_pass_nonposted_enable;
    wire [17:0] l0s_lat, l1_lat;
    wire [11:0] mps, aspm;
    ecl_loader dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q,
        .pslverr_q, .ee_word_valid, .ee_word_addr, .ee_word_data, .ee_word_last, .ee_word_ready_q,
        .vendor_id_q, .device_id_q, .subsys_vendor_id_q, .subsys_id_q, .sw_no_order_egress_q,
        .sw_no_order_tag_q, .sw_store_fwd_q, .sw_cut_thresh_q, .sw_arb_mode_q, .sw_credit_mode_q,
        .sw_np_store_fwd_q, .vc_ext, .l0s_lat, .l1_lat, .clk_pm, .mps, .aspm, .rber, .msi_dis, .cpp_dis,
        .pm_dis, .posted_pass_nonposted_enable, .load_done_q, .sig_err_q);
    ecl_ee_model ee_u (.pclk, .run, .slow, .sig, .w06, .w0c, .id, .ready(ee_word_ready_q),
        .valid(ee_word_valid), .addr(ee_word_addr), .data(ee_word_data), .last(ee_word_last));
    always #20 pclk = ~pclk;
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task end_of_test;
        $display("Checks %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One idle edge first, so a release and a new setup never share a time step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready_q !== 1'b1 && n < 50);
        rd_v = prdata_q;
        er_v = pslverr_q;
        chk("apb_wait", n < 50, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task load(input logic [15:0] s, input logic [15:0] a, input logic [15:0] c, input logic [15:0] i,
        input logic sl);
        integer n;
        sig <= s;
        w06 <= a;
        w0c <= c;
        id <= i;
        slow <= sl;
        run <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (ee_word_ready_q !== 1'b1 && n < 20);
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (load_done_q !== 1'b1 && sig_err_q !== 1'b1 && n < 60);
        chk("load_wait", n < 60, 1);
        run <= 1'b0;
        @(posedge pclk);
    endtask
    task fields(input logic [15:0] a, input logic [15:0] c, input logic [15:0] i);
        chk("vendor", vendor_id_q, i);
        chk("device", device_id_q, i ^ 16'hFFFF);
        chk("ss_vendor", subsys_vendor_id_q, i ^ 16'h0F0F);
        chk("ss_id", subsys_id_q, i ^ 16'hF0F0);
        chk("vc", vc_ext, {6{a[0]}});
        chk("l0s", l0s_lat, {6{a[3:1]}});
        chk("l1", l1_lat, {6{a[6:4]}});
        chk("clk_pm", clk_pm, {6{a[7]}});
        chk("no_egress", sw_no_order_egress_q, a[8]);
        chk("no_tag", sw_no_order_tag_q, a[9]);
        chk("store_fwd", sw_store_fwd_q, a[10]);
        chk("cut", sw_cut_thresh_q, a[12:11]);
        chk("arb", sw_arb_mode_q, a[13]);
        chk("credit", sw_credit_mode_q, a[14]);
        chk("np_sf", sw_np_store_fwd_q, a[15]);
        chk("mps", mps, {6{c[1:0]}});
        chk("aspm", aspm, {6{c[3:2]}});
        chk("rber", rber, {6{c[4]}});
        chk("msi", msi_dis, {6{c[5]}});
        chk("cpp", cpp_dis, {6{c[6]}});
        chk("pm", pm_dis, {6{c[7]}});
        chk("pass_np", posted_pass_nonposted_enable, {6{c[8]}});
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        fails = fails + 1;
        end_of_test;
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, run, slow} = 7'h00;
        {paddr, pwdata, sig, w06, w0c, id} = 104'h0;
        fails = 0;
        cmp_count = 0;
        repeat (16) @(posedge pclk);
        chk("rst_ready", ee_word_ready_q, 0);
        chk("rst_vendor", vendor_id_q, 0);
        presetn <= 1'b1;
        load(`ECL_SIG_RST, 16'hB2D5, 16'h0155, 16'h1C3E, 1'b0);
        fields(16'hB2D5, 16'h0155, 16'h1C3E);
        apb(1'b0, `ECL_REG_STAT, 0);
        chk("stat_ok", rd_v, 32'h0000000A);
        apb(1'b1, `ECL_REG_CTRL, 1);
        load(`ECL_SIG_RST, 16'h4D2A, 16'hFEAA, 16'hE3C1, 1'b1);
        fields(16'h4D2A, 16'hFEAA, 16'hE3C1);
        apb(1'b1, `ECL_REG_SIGEXP, 32'h00001234);
        apb(1'b0, `ECL_REG_SIGEXP, 0);
        chk("sig_exp", rd_v, 32'h00001234);
        apb(1'b1, `ECL_REG_CTRL, 1);
        load(`ECL_SIG_RST, 16'hB2D5, 16'h0155, 16'h1C3E, 1'b0);
        chk("sig_err", sig_err_q, 1);
        chk("no_done", load_done_q, 0);
        fields(16'h4D2A, 16'hFEAA, 16'hE3C1);
        apb(1'b0, `ECL_REG_STAT, 0);
        chk("stat_err", rd_v, 32'h00000004);
        apb(1'b0, `ECL_REG_SIGSEEN, 0);
        chk("sig_seen", rd_v, {16'h0000, `ECL_SIG_RST});
        apb(1'b0, `ECL_REG_ID, 0);
        chk("id_word", rd_v, 32'h1C3EE3C1);
        apb(1'b0, `ECL_REG_SSID, 0);
        chk("ssid_word", rd_v, 32'h1331ECCE);
        apb(1'b1, `ECL_REG_W06, 32'h0000FFFF);
        chk("ro_err", er_v, 0);
        apb(1'b0, `ECL_REG_W06, 0);
        chk("w06_word", rd_v, 32'h00004D2A);
        apb(1'b0, `ECL_REG_W0C, 0);
        chk("w0c_word", rd_v, 32'h0000FEAA);
        apb(1'b0, 8'h40, 0);
        chk("unmapped_err", er_v, 1);
        chk("unmapped_data", rd_v, 0);
        end_of_test;
    end
endmodule
